// ### design/eeprom_map_consts.svh
`ifndef EEPROM_MAP_CONSTS_SVH
`define EEPROM_MAP_CONSTS_SVH

// Geometry
`define EE_ADDR_W          9
`define EE_BYTES           512
`define EE_BLOCK_SHIFT     4
`define EE_BLOCK_W         5
// Block boundaries
`define EE_BLK_INFO        5'h00
`define EE_BLK_RW_LAST     5'h07
`define EE_BLK_KEY_FIRST   5'h08
// Start-up copy window
`define EE_INIT_FIRST      9'h010
`define EE_INIT_LAST       9'h02F
`define EE_PAGE_MASK       3'h0
// Product information byte positions
`define EE_IDX_VERSION     4'h4
`define EE_IDX_SERIAL0     4'h8
`define EE_IDX_TRIM0       4'hC
`define EE_IDX_RSMAX       4'hE
`define EE_IDX_CHECK       4'hF
// Check byte preset
`define EE_CHECK_PRESET    8'h00

`endif

// ### design/eeprom_map_pkg.sv
package eeprom_map_pkg;
  typedef logic [8:0] ee_addr_t;

  // Command from the command engine
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [8:0] addr;
    logic [7:0] wdata;
  } ee_req_s;

  // Answer to the command engine
  typedef struct packed {
    logic       done;
    logic       err;
    logic [7:0] rdata;
  } ee_rsp_s;

  // Start-up register load strobe
  typedef struct packed {
    logic       valid;
    logic [5:0] addr;
    logic [7:0] data;
  } ee_init_s;

  typedef enum logic [1:0] {
    ST_CHECK = 2'b00,
    ST_LOAD  = 2'b01,
    ST_READY = 2'b11
  } ee_state_e;
endpackage : eeprom_map_pkg

// ### design/eeprom_map_access_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_map_consts.svh"

module eeprom_map_access_control
  import eeprom_map_pkg::*;
(
  input  wire logic    core_clk,
  input  wire logic    rstn,
  input  wire ee_req_s req,
  output var  ee_rsp_s rsp_q,
  output var  ee_init_s init_q,
  output logic         init_done_q,
  output logic         check_ok_q,
  output logic [7:0]   max_pchannel_source_resistance_q,
  output logic [15:0]  trim_q
);

  ////////////////////////////////////////////////////////////////
  // Storage and address decode

  // Array and start-up state
  logic [7:0]    mem [0:`EE_BYTES-1];
  ee_state_e     state_q;
  ee_addr_t      ptr_q;
  logic [7:0]    sum_q;

  // Request decode
  logic [4:0]    req_blk;
  logic          in_info;
  logic          in_key;
  logic          wr_ok;
  logic          rd_ok;
  logic          wr_bad;
  logic          rd_bad;
  logic          busy;

  // Start-up end points and next output values
  logic          check_end;
  logic          load_end;
  logic          calib_grab;
  ee_rsp_s       rsp_d;
  ee_init_s      init_d;

  // Block number and region of the requested byte
  assign req_blk = req.addr[`EE_ADDR_W-1:`EE_BLOCK_SHIFT];
  assign in_info = (req_blk == `EE_BLK_INFO);
  assign in_key  = (req_blk >= `EE_BLK_KEY_FIRST);

  // Every request is refused until the start-up copy is over
  assign busy    = (state_q != ST_READY);

  // Access rules: info field read-only, key blocks write-only
  assign wr_bad  = req.wr && in_info;
  assign rd_bad  = req.rd && in_key;
  assign wr_ok   = !busy && req.wr && !wr_bad;
  assign rd_ok   = !busy && req.rd && !rd_bad;

  ////////////////////////////////////////////////////////////////
  // Array write port, block 0 never written

  // Plain always so the nonvolatile content can be preloaded
  // A read in the next cycle already sees the new byte
  always @(posedge core_clk) begin
    if (wr_ok) begin
      mem[req.addr] <= req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Start-up sequencer: check field, then copy init image

  // End points of the two start-up passes
  assign check_end = (state_q == ST_CHECK) && (ptr_q[3:0] == `EE_IDX_CHECK);
  assign load_end  = (state_q == ST_LOAD) && (ptr_q == `EE_INIT_LAST);

  // Phase register, ready is held until the next reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_CHECK;
    end else begin
      unique case (state_q)
        ST_CHECK: begin
          if (check_end) begin
            state_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (load_end) begin
            state_q <= ST_READY;
          end
        end
        ST_READY: begin
          state_q <= ST_READY;
        end
      endcase
    end
  end

  // Byte pointer, jumps from the check byte to the init image
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ptr_q <= 9'h000;
    end else if (check_end) begin
      ptr_q <= `EE_INIT_FIRST;
    end else if (busy && !load_end) begin
      ptr_q <= ptr_q + 9'h001;
    end
  end

  // Running XOR over bytes 0 to 14 of the info field
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sum_q <= `EE_CHECK_PRESET;
    end else if (state_q == ST_CHECK && !check_end) begin
      sum_q <= sum_q ^ mem[ptr_q];
    end
  end

  // Check byte compare, reported only, start-up goes on anyway
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      check_ok_q <= 1'b0;
    end else if (check_end) begin
      check_ok_q <= (sum_q == mem[ptr_q]);
    end
  end

  // Start-up finished flag
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      init_done_q <= 1'b0;
    end else if (load_end) begin
      init_done_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Register load strobe, page-select slots skipped

  // Next strobe, straight from the pointer during the load pass
  // Page-select slots give no strobe but still take a cycle
  always_comb begin
    init_d       = '0;
    init_d.valid = (state_q == ST_LOAD) && (ptr_q[2:0] != `EE_PAGE_MASK);
    init_d.addr  = ptr_q[5:0];
    init_d.data  = mem[ptr_q];
  end

  // Strobe register feeding the register file
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      init_q <= '0;
    end else begin
      init_q <= init_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Calibration values read out of block 0 for internal use

  // Taken once, on the first cycle of the load pass
  assign calib_grab = (state_q == ST_LOAD) && (ptr_q == `EE_INIT_FIRST);

  // Source resistance byte for the driver setup
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      max_pchannel_source_resistance_q <= 8'h00;
    end else if (calib_grab) begin
      max_pchannel_source_resistance_q <= mem[{5'h00, `EE_IDX_RSMAX}];
    end
  end

  // Trimming pair, high byte from the odd address
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      trim_q <= 16'h0000;
    end else if (calib_grab) begin
      trim_q <= {mem[{5'h00, `EE_IDX_TRIM0} + 9'h001], mem[{5'h00, `EE_IDX_TRIM0}]};
    end
  end

  ////////////////////////////////////////////////////////////////
  // Command answer: one cycle after the request

  // Refused and busy requests still answer, with zero data
  // Zero data on refusal keeps key bytes inside the array
  always_comb begin
    rsp_d      = '0;
    rsp_d.done = req.rd || req.wr;
    rsp_d.err  = busy ? (req.rd || req.wr) : (wr_bad || rd_bad);
    if (rd_ok) begin
      rsp_d.rdata = mem[req.addr];
    end
  end

  // Answer register seen by the command engine
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

endmodule : eeprom_map_access_control

`default_nettype wire

// ### sim/init_reg_sink.sv
`timescale 1ns/1ps
`default_nettype none
module init_reg_sink
  import eeprom_map_pkg::*;
(
  input  wire logic     core_clk,
  input  wire ee_init_s init_q,
  output bit [7:0]      regs [64],
  output int            loads
);
  // Registers filled by the start-up copy
  always @(posedge core_clk) if (init_q.valid === 1'b1) begin
    regs[init_q.addr] <= init_q.data;
    loads <= loads + 1;
  end
endmodule : init_reg_sink
`default_nettype wire

// ### sim/eeprom_map_access_control_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ee_map_checker
  import eeprom_map_pkg::*;
(
  input wire logic     core_clk,
  input wire logic     rstn,
  input wire ee_req_s  req,
  input wire ee_rsp_s  rsp_q,
  input wire ee_init_s init_q,
  input wire logic     init_done_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_done_next: assert property ((req.rd | req.wr) |=> rsp_q.done) else $error("done missing");
  a_no_extra: assert property (!(req.rd | req.wr) |=> !rsp_q.done) else $error("stray done");
  a_info_wr: assert property (req.wr && req.addr[8:4] == 5'h00 |=> rsp_q.err) else $error("info write");
  a_key_hidden: assert property (req.rd && req.addr[8:7] != 2'h0 |=> rsp_q.err && rsp_q.rdata == 8'h00)
    else $error("key read");
  a_rw_open: assert property (init_done_q && (req.rd ^ req.wr) && req.addr[8:7] == 2'h0 && req.addr[8:4] != 5'h00
    |=> !rsp_q.err) else $error("rw refused");
  a_busy_err: assert property (!init_done_q && (req.rd | req.wr) |=> rsp_q.err) else $error("busy ok");
  a_page_skip: assert property (init_q.valid |-> init_q.addr[2:0] != 3'h0 && init_q.addr inside {[6'h11:6'h2F]})
    else $error("bad load");
  a_load_step: assert property (init_q.valid && init_q.addr[2:0] != 3'h7
    |=> init_q.valid && init_q.addr == $past(init_q.addr) + 6'h01) else $error("load gap");
  c_load: cover property (init_q.valid);
  c_err: cover property (rsp_q.done && rsp_q.err);
  c_ok: cover property (rsp_q.done && !rsp_q.err);
endmodule : ee_map_checker
bind eeprom_map_access_control ee_map_checker u_chk(.core_clk(core_clk), .rstn(rstn), .req(req), .rsp_q(rsp_q),
  .init_q(init_q), .init_done_q(init_done_q));
`default_nettype wire

// ### sim/eeprom_map_access_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_map_access_control_tb;
  import eeprom_map_pkg::*;
  logic core_clk, rstn, init_done_q, check_ok_q;
  ee_req_s req;
  ee_rsp_s rsp_q;
  ee_init_s init_q;
  logic [7:0] rmax, gold [512];
  logic [15:0] trim;
  bit [7:0] regs [64];
  int loads, err_total, total_checks;
  logic [8:0] notes [$];
  logic [8:0] probe_addr [6] = '{9'h005, 9'h010, 9'h02F, 9'h07F, 9'h080, 9'h1FF};
  eeprom_map_access_control i_dut(.core_clk(core_clk), .rstn(rstn), .req(req), .rsp_q(rsp_q), .init_q(init_q),
    .init_done_q(init_done_q), .check_ok_q(check_ok_q), .max_pchannel_source_resistance_q(rmax), .trim_q(trim));
  init_reg_sink i_sink(.core_clk(core_clk), .init_q(init_q), .regs(regs), .loads(loads));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task give_verdict;
    if (err_total == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // Drive one request and note its answer
  task send(input logic r, input logic w, input logic [8:0] a, input logic [7:0] d, input logic busy);
    logic e;
    e = busy | (w & a[8:4] == 5'h00) | (r & a[8:7] != 2'h0);
    if (w & !e) gold[a] = d;
    if (r | w) notes.push_back({e, (r & !e) ? gold[a] : 8'h00});
    req <= '{r, w, a, d};
    @(posedge core_clk);
  endtask : send
  //////////////////////////////////////////////////
  // Clock and watchdog
  initial begin core_clk = 0; forever #5 core_clk = ~core_clk; end
  initial begin repeat (5000) @(posedge core_clk); err_total++; give_verdict; end
  // Answer monitor
  always @(negedge core_clk) if (rstn && rsp_q.done === 1'b1) chk({rsp_q.err, rsp_q.rdata}, notes.pop_front());
  // Main sequence
  initial begin
    void'($urandom(75174));
    rstn = 0;
    req = '0;
    for (int i = 0; i < 512; i++) gold[i] = 8'($urandom);
    gold[15] = 8'h00;
    for (int i = 0; i < 15; i++) gold[15] ^= gold[i];
    for (int i = 0; i < 512; i++) i_dut.mem[i] = gold[i];
    repeat (4) @(posedge core_clk);
    rstn <= 1;
    @(posedge core_clk);
    send(1, 0, 9'h030, 8'h00, 1);
    req <= '0;
    for (int i = 0; i < 100 && init_done_q !== 1'b1; i++) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
    chk(init_done_q, 1);
    chk(check_ok_q, 1);
    chk(rmax, gold[14]);
    chk(trim, {gold[13], gold[12]});
    chk(loads, 28);
    for (int a = 16; a < 48; a++) chk(regs[a], a[2:0] ? gold[a] : 8'h00);
    for (int a = 0; a < 16; a++) send(1, 0, 9'(a), 8'h00, 0);
    for (int k = 0; k < 6; k++) begin
      send(0, 1, probe_addr[k], 8'($urandom), 0);
      send(1, 0, probe_addr[k], 8'h00, 0);
    end
    for (int i = 0; i < 2000; i++) send(i % 3 == 1, i % 3 == 2, 9'($urandom), 8'($urandom), 0);
    req <= '0;
    repeat (3) @(posedge core_clk);
    chk(notes.size(), 0);
    give_verdict;
  end
endmodule : eeprom_map_access_control_tb
`default_nettype wire
